// File: verilog/csc_pkg.sv
// Constants, carriers and state codes for the processor sideband control block
package csc_pkg;

    // Register bus widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // Register offsets (I/O addresses)
    localparam logic [15:0] SYS_PORT_ADDR  = 16'h0092;
    localparam logic [15:0] FPU_CLR_ADDR   = 16'h00f0;
    localparam logic [15:0] FPU_CTRL_ADDR  = 16'h00f4;
    localparam logic [15:0] STATUS_ADDR    = 16'h00f5;
    localparam logic [15:0] RST_CTRL_ADDR  = 16'h0cf9;

    // Field positions
    localparam int SYS_INIT_BIT     = 0;
    localparam int SYS_FAST_ADDR20_BIT_BIT = 1;
    localparam int RC_SYS_RST_BIT   = 1;
    localparam int RC_CPU_RST_BIT   = 2;
    localparam int FPU_EN_BIT       = 0;
    localparam int ST_CPU_RST_BIT   = 0;
    localparam int ST_INIT_BIT      = 1;
    localparam int ST_IGNORE_BIT    = 2;
    localparam int ST_FPU_IRQ_BIT   = 3;
    localparam int ST_STRAP_BIT     = 4;

    // Reset values
    localparam logic [7:0] SYS_PORT_RST = 8'h00;
    localparam logic [7:0] RST_CTRL_RST = 8'h00;
    localparam logic [7:0] FPU_CTRL_RST = 8'h01;
    localparam logic [7:0] RDATA_RST    = 8'h00;

    // Timing
    localparam int CLK_MHZ     = 125;
    localparam int CPU_RST_MS  = 2;
    localparam int CPU_RST_CYC = CPU_RST_MS * CLK_MHZ * 1000;
    localparam int INIT_CYC    = 64;

    // Register bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } csc_bus_t;

    // Pins from outside the clock domain
    typedef struct packed {
        logic power_good;
        logic addr20_gate;
        logic fpu_error_n;
        logic kbc_reset_request_n;
        logic processor_type_strap;
    } csc_pins_t;

    localparam csc_pins_t PINS_IDLE = 5'h06;

    // Processor reset sequencer
    typedef enum logic [2:0] {
        RS_WAIT_PG = 3'h1,
        RS_HOLD    = 3'h2,
        RS_RUN     = 3'h4
    } csc_rst_state_t;

endpackage

// File: verilog/csc_sideband.sv
// Processor sideband control: address-20 mask, processor reset, init, FPU error
// Function
// - Address-20 mask output follows fast address-20 bit and gate input.
// - Processor reset asserted at power-up and on hard reset request.
// - Processor reset held at least 2 ms after power good goes active.
// - Hard reset through reset control register holds reset at least 2 ms.
// - Processor reset release happens on a rising clock edge.
// - Hard reset request returns the port registers, init pulse and ignore flag to defaults.
// - Strap picks reset and init polarity: high newer, low older family.
// - FPU error input raises the internal FPU interrupt line.
// - Ignore output driven only while FPU error reporting is enabled.
// - FPU clear write during error asserts ignore until error negates.
// - Ignore never asserted unless the FPU error input is active.
// - System reset bit 0 and reset-processor 0 to 1 starts init.
// - Shutdown special cycle starts init.
// - Keyboard controller reset request starts init.
// - System control port write with bit 0 set starts init.
// - Each init pulse lasts 64 clock cycles unless a hard reset request cuts it short.
// - Processor interrupt output signals a pending interrupt request.
// - Processor interrupt output low during and after reset.
// - Open-drain mask and ignore outputs float during reset; after reset ignore floats and mask pulls low.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module csc_sideband #(
    parameter int RST_CYCLES = csc_pkg::CPU_RST_CYC,
    parameter int INIT_CYCLES = csc_pkg::INIT_CYC
) (
    // Clock and reset
    input  wire logic              mclk_in,
    input  wire logic              reset_n_in,
    // Register port
    input  wire csc_pkg::csc_bus_t bus_in,
    output logic [7:0]             rdata_out,
    // Asynchronous pins
    input  wire csc_pkg::csc_pins_t pins_in,
    // Same-clock events
    input  wire logic              shutdown_cycle_in,
    input  wire logic              irq_pending_in,
    // Processor controls
    output logic                   processor_reset_out,
    output logic                   init_out,
    output logic                   processor_irq_out,
    output logic                   fpu_irq_line_out,
    // Open-drain pins
    output logic                   addr20_mask_out,
    output logic                   addr20_mask_oe_out,
    output logic                   ignore_fpu_error_out,
    output logic                   ignore_fpu_error_oe_out
);

    localparam int CNT_W = $clog2(RST_CYCLES + 1);
    localparam int ICNT_W = $clog2(INIT_CYCLES + 1);
    localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RST_CYCLES - 1);
    localparam logic [ICNT_W-1:0] INIT_LAST = ICNT_W'(INIT_CYCLES - 1);

    function automatic logic hit(input csc_pkg::csc_bus_t b, input logic [15:0] a);
        hit = (b.addr == a);
    endfunction

    // Pin synchronisers
    csc_pkg::csc_pins_t sync1;
    csc_pkg::csc_pins_t sync2;
    csc_pkg::csc_pins_t sync3;
    csc_pkg::csc_pins_t filt;

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            sync1 <= csc_pkg::PINS_IDLE;
            sync2 <= csc_pkg::PINS_IDLE;
            sync3 <= csc_pkg::PINS_IDLE;
        end else begin
            sync1 <= pins_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // A change only counts once two stages agree, which rejects a glitch on one edge
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_filt
            always_ff @(posedge mclk_in) begin
                if (!reset_n_in) begin
                    filt[gi] <= csc_pkg::PINS_IDLE[gi];
                end else if (sync2[gi] == sync3[gi]) begin
                    filt[gi] <= sync3[gi];
                end
            end
        end
    endgenerate

    logic err_act;
    logic gate_act;
    assign err_act = !filt.fpu_error_n;
    assign gate_act = filt.addr20_gate;

    // Strap is followed through the filter, so polarity settles a few cycles after reset release
    logic strap_taken;
    logic strap_newer;

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            strap_taken <= 1'b0;
            strap_newer <= 1'b0;
        end else begin
            strap_taken <= 1'b1;
            strap_newer <= filt.processor_type_strap;
        end
    end

    // Register decode
    logic wr_sys;
    logic wr_rc;
    logic wr_fctl;
    logic wr_fclr;
    assign wr_sys = bus_in.wr && hit(bus_in, csc_pkg::SYS_PORT_ADDR);
    assign wr_rc = bus_in.wr && hit(bus_in, csc_pkg::RST_CTRL_ADDR);
    assign wr_fctl = bus_in.wr && hit(bus_in, csc_pkg::FPU_CTRL_ADDR);
    assign wr_fclr = bus_in.wr && hit(bus_in, csc_pkg::FPU_CLR_ADDR);

    logic [7:0] sys_port;
    logic [7:0] rst_ctrl;
    logic [7:0] fpu_ctrl;
    logic       hard_req;
    logic       regs_rst;
    logic       cpu_rise;
    logic       soft_rc;
    logic       next_hard_req;

    assign cpu_rise = wr_rc && bus_in.wdata[csc_pkg::RC_CPU_RST_BIT]
                      && !rst_ctrl[csc_pkg::RC_CPU_RST_BIT];
    assign soft_rc = cpu_rise && !bus_in.wdata[csc_pkg::RC_SYS_RST_BIT];
    assign next_hard_req = cpu_rise && bus_in.wdata[csc_pkg::RC_SYS_RST_BIT];
    // Hard reset clears every soft register, the same as a bus reset
    assign regs_rst = !reset_n_in || hard_req;

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            hard_req <= 1'b0;
        end else begin
            hard_req <= next_hard_req;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (regs_rst) begin
            sys_port <= csc_pkg::SYS_PORT_RST;
            rst_ctrl <= csc_pkg::RST_CTRL_RST;
            fpu_ctrl <= csc_pkg::FPU_CTRL_RST;
        end else begin
            if (wr_sys) begin
                sys_port <= bus_in.wdata;
            end
            if (wr_rc) begin
                rst_ctrl <= bus_in.wdata;
            end
            if (wr_fctl) begin
                fpu_ctrl <= bus_in.wdata;
            end
        end
    end

    logic fpu_en;
    logic fast_addr20_bit;
    assign fpu_en = fpu_ctrl[csc_pkg::FPU_EN_BIT];
    assign fast_addr20_bit = sys_port[csc_pkg::SYS_FAST_ADDR20_BIT_BIT];

    // Processor reset sequencer
    csc_pkg::csc_rst_state_t rs_state;
    logic [CNT_W-1:0]        rs_cnt;
    logic                    cpu_rst_act;

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            rs_state <= csc_pkg::RS_WAIT_PG;
            rs_cnt <= '0;
        end else begin
            case (rs_state)
                csc_pkg::RS_WAIT_PG: begin
                    rs_cnt <= '0;
                    if (filt.power_good) begin
                        rs_state <= csc_pkg::RS_HOLD;
                    end
                end
                csc_pkg::RS_HOLD: begin
                    if (!filt.power_good) begin
                        rs_state <= csc_pkg::RS_WAIT_PG;
                        rs_cnt <= '0;
                    end else if (rs_cnt == RST_LAST) begin
                        rs_state <= csc_pkg::RS_RUN;
                        rs_cnt <= '0;
                    end else begin
                        rs_cnt <= rs_cnt + CNT_W'(1);
                    end
                end
                csc_pkg::RS_RUN: begin
                    rs_cnt <= '0;
                    if (!filt.power_good) begin
                        rs_state <= csc_pkg::RS_WAIT_PG;
                    end else if (hard_req) begin
                        rs_state <= csc_pkg::RS_HOLD;
                    end
                end
                default: begin
                    rs_state <= csc_pkg::RS_WAIT_PG;
                    rs_cnt <= '0;
                end
            endcase
        end
    end

    assign cpu_rst_act = (rs_state != csc_pkg::RS_RUN);

    // Init pulse generator
    logic              kbc_prev;
    logic              kbc_fall;
    logic              init_trig;
    logic              init_act;
    logic [ICNT_W-1:0] init_cnt;

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            kbc_prev <= 1'b1;
        end else begin
            kbc_prev <= filt.kbc_reset_request_n;
        end
    end

    assign kbc_fall = kbc_prev && !filt.kbc_reset_request_n;
    assign init_trig = soft_rc || shutdown_cycle_in || kbc_fall
                       || (wr_sys && bus_in.wdata[csc_pkg::SYS_INIT_BIT]);

    // A trigger during a pulse is dropped, so only a hard reset request cuts the pulse short
    always_ff @(posedge mclk_in) begin
        if (regs_rst) begin
            init_act <= 1'b0;
            init_cnt <= '0;
        end else if (!init_act) begin
            init_cnt <= '0;
            if (init_trig) begin
                init_act <= 1'b1;
            end
        end else if (init_cnt == INIT_LAST) begin
            init_act <= 1'b0;
            init_cnt <= '0;
        end else begin
            init_cnt <= init_cnt + ICNT_W'(1);
        end
    end

    // Ignore-exception flag
    logic ign_flag;

    always_ff @(posedge mclk_in) begin
        if (regs_rst) begin
            ign_flag <= 1'b0;
        end else if (!err_act) begin
            ign_flag <= 1'b0;
        end else if (wr_fclr && fpu_en) begin
            ign_flag <= 1'b1;
        end
    end

    // Output flops; polarity of reset and init follows the strap
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            processor_reset_out <= 1'b1;
            init_out <= 1'b0;
        end else begin
            processor_reset_out <= cpu_rst_act ^ strap_newer;
            init_out <= init_act ^ strap_newer;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            processor_irq_out <= 1'b0;
            fpu_irq_line_out <= 1'b0;
        end else begin
            processor_irq_out <= irq_pending_in;
            fpu_irq_line_out <= err_act;
        end
    end

    // Open-drain pins only ever pull low, so the data flops stay at zero
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            addr20_mask_out <= 1'b0;
            addr20_mask_oe_out <= 1'b0;
            ignore_fpu_error_out <= 1'b0;
            ignore_fpu_error_oe_out <= 1'b0;
        end else begin
            addr20_mask_out <= 1'b0;
            addr20_mask_oe_out <= !fast_addr20_bit && !gate_act;
            ignore_fpu_error_out <= 1'b0;
            ignore_fpu_error_oe_out <= ign_flag && fpu_en && err_act;
        end
    end

    // Read data, one cycle after the strobe
    logic [7:0] status;
    always_comb begin
        status = 8'h00;
        status[csc_pkg::ST_CPU_RST_BIT] = cpu_rst_act;
        status[csc_pkg::ST_INIT_BIT] = init_act;
        status[csc_pkg::ST_IGNORE_BIT] = ign_flag;
        status[csc_pkg::ST_FPU_IRQ_BIT] = err_act;
        status[csc_pkg::ST_STRAP_BIT] = strap_newer;
    end

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            rdata_out <= csc_pkg::RDATA_RST;
        end else if (bus_in.rd) begin
            if (hit(bus_in, csc_pkg::SYS_PORT_ADDR)) begin
                rdata_out <= sys_port;
            end else if (hit(bus_in, csc_pkg::RST_CTRL_ADDR)) begin
                rdata_out <= rst_ctrl;
            end else if (hit(bus_in, csc_pkg::FPU_CTRL_ADDR)) begin
                rdata_out <= fpu_ctrl;
            end else if (hit(bus_in, csc_pkg::STATUS_ADDR)) begin
                rdata_out <= status;
            end else begin
                rdata_out <= 8'h00;
            end
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // Checks
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence s_soft_rc;
        soft_rc && !init_act;
    endsequence

    sequence s_p92_init;
        wr_sys && bus_in.wdata[csc_pkg::SYS_INIT_BIT] && !init_act;
    endsequence

    sequence s_init_start;
        init_act && init_cnt == '0;
    endsequence

    a_a20_mask_level: assert property (
        strap_taken |-> addr20_mask_oe_out == $past(!fast_addr20_bit && !gate_act))
        else $error("address-20 mask does not follow its inputs");

    a_init_soft_rc: assert property (
        s_soft_rc |=> s_init_start)
        else $error("soft reset request did not start init");

    a_init_port92: assert property (
        s_p92_init |=> s_init_start)
        else $error("system control port write did not start init");

    a_init_shutdown: assert property (
        shutdown_cycle_in && !init_act && !hard_req |=> s_init_start)
        else $error("shutdown cycle did not start init");

    a_init_width: assert property (
        $fell(init_act) && !$past(hard_req) |-> $past(init_cnt) == INIT_LAST)
        else $error("init pulse length wrong");

    a_init_no_cut: assert property (
        init_act && init_trig && init_cnt != INIT_LAST && !hard_req |=> init_act)
        else $error("new trigger cut the init pulse");

    a_ignore_gate: assert property (
        ignore_fpu_error_oe_out |-> $past(err_act))
        else $error("ignore asserted without FPU error");

    a_ignore_set_hold: assert property (
        wr_fclr && fpu_en && err_act && !hard_req ##1 err_act [*2] |-> ign_flag)
        else $error("ignore not held while FPU error active");

    a_cpu_rst_min: assert property (
        $rose(rs_state == csc_pkg::RS_RUN) |-> $past(rs_cnt) == RST_LAST)
        else $error("processor reset released early");

    a_hard_rst_regs: assert property (
        hard_req |=> sys_port == csc_pkg::SYS_PORT_RST && rst_ctrl == csc_pkg::RST_CTRL_RST
                     && rs_state == csc_pkg::RS_HOLD)
        else $error("hard reset did not restore registers");

    a_irq_after_rst: assert property (
        $rose(reset_n_in) |-> !processor_irq_out)
        else $error("processor interrupt not low after reset");

endmodule

// File: test/csc_cpu_model.sv
// Processor core model that watches the sideband pins of the block
`timescale 1ns/1ps
module csc_cpu_model (
    // Clock
    input  wire logic mclk_in,
    // Strap and pins from the block
    input  wire logic strap_in,
    input  wire logic init_in,
    input  wire logic a20_pin_in,
    input  wire logic ignore_fpu_error_out_pin_in,
    // Observations for the bench
    output int        init_count_out,
    output int        init_width_out,
    output logic      a20_masked_out,
    output logic      ignoring_out
);
    int   run = 0;
    logic init_act;

    // Strap picks which level means init active
    assign init_act       = init_in ^ strap_in;
    // Open-drain pins read low while pulled, high through the pull-up otherwise
    assign a20_masked_out = ~a20_pin_in;
    assign ignoring_out   = ~ignore_fpu_error_out_pin_in;

    initial begin
        init_count_out = 0;
        init_width_out = 0;
    end

    // A pulse is counted only when it ends, so its width is known then
    always @(posedge mclk_in) begin
        if (init_act) begin
            run <= run + 1;
        end else if (run != 0) begin
            init_width_out <= run;
            init_count_out <= init_count_out + 1;
            run            <= 0;
        end
    end
endmodule

// File: test/tb.sv
// Self-checking testbench for the processor sideband control block
`timescale 1ns/1ps
module tb;
    localparam int      RST_CYC = 20;
    logic               mclk_in    = 1'b0;
    logic               reset_n_in = 1'b0;
    logic               shut       = 1'b0;
    logic               irq_pend   = 1'b0;
    csc_pkg::csc_bus_t  bus        = '0;
    csc_pkg::csc_pins_t pins       = csc_pkg::PINS_IDLE;
    logic [7:0]         rdata;
    logic               proc_rst, init, proc_irq, fpu_irq;
    logic               a20_out, a20_oe, ign_out, ign_oe, masked, ignoring;
    logic [7:0]         r, d;
    int                 icount, iwidth, k, t, n, c0;
    int                 fails      = 0;
    int                 n_compared = 0;
    integer             seed;

    initial begin
        forever #4 mclk_in = ~mclk_in;
    end

    csc_sideband #(.RST_CYCLES(RST_CYC)) csc_sideband_inst (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .bus_in(bus), .rdata_out(rdata),
        .pins_in(pins), .shutdown_cycle_in(shut), .irq_pending_in(irq_pend),
        .processor_reset_out(proc_rst), .init_out(init), .processor_irq_out(proc_irq),
        .fpu_irq_line_out(fpu_irq), .addr20_mask_out(a20_out), .addr20_mask_oe_out(a20_oe),
        .ignore_fpu_error_out(ign_out), .ignore_fpu_error_oe_out(ign_oe));

    // Pull-ups on the open-drain pins
    csc_cpu_model csc_cpu_model_inst (
        .mclk_in(mclk_in), .strap_in(pins.processor_type_strap), .init_in(init),
        .a20_pin_in(a20_oe ? a20_out : 1'b1), .ignore_fpu_error_out_pin_in(ign_oe ? ign_out : 1'b1),
        .init_count_out(icount), .init_width_out(iwidth), .a20_masked_out(masked),
        .ignoring_out(ignoring));

    task automatic report_and_stop;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic cycles(input int c);
        repeat (c) @(posedge mclk_in);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge mclk_in);
        bus.addr  <= a;
        bus.wdata <= v;
        bus.wr    <= 1'b1;
        @(posedge mclk_in);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge mclk_in);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge mclk_in);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic wait_rst(output int cnt);
        cnt = 0;
        while (proc_rst !== 1'b0) begin
            cycles(1);
            cnt++;
            if (cnt > 300) begin
                fails++;
                report_and_stop();
            end
        end
    endtask

    task automatic wait_init(input int base);
        int w;
        w = 0;
        while (icount == base) begin
            cycles(1);
            w++;
            if (w > 300) begin
                fails++;
                report_and_stop();
            end
        end
    endtask

    initial begin
        seed = 32'h114042a0;
        @(posedge mclk_in);
        @(posedge mclk_in);
        reset_n_in <= 1'b1;
        #1;
        check("rst_in_reset", proc_rst, 1'b1);
        check("irq_in_reset", proc_irq, 1'b0);
        check("oe_in_reset", {a20_oe, ign_oe}, 2'h0);
        cycles(3);
        check("rst_before_pg", proc_rst, 1'b1);
        @(posedge mclk_in) pins.power_good <= 1'b1;
        wait_rst(n);
        check("pg_hold_min", n >= RST_CYC, 1'b1);
        check("pg_hold_max", n <= RST_CYC + 8, 1'b1);
        $display("Test power_up done");

        for (k = 0; k < 4; k++) begin
            @(posedge mclk_in) pins.addr20_gate <= k[1];
            wr(csc_pkg::SYS_PORT_ADDR, {6'h00, k[0], 1'b0});
            cycles(6);
            check("a20_mask", masked, !k[0] && !k[1]);
        end
        // Random port values keep bit 0 clear so no init starts here
        for (k = 0; k < 8; k++) begin
            d = 8'($random(seed)) & 8'hfe;
            wr(csc_pkg::SYS_PORT_ADDR, d);
            rd(csc_pkg::SYS_PORT_ADDR, r);
            check("sys_port_rw", r, d);
            cycles(5);
            check("a20_rand", masked, !d[1] && !pins.addr20_gate);
            rd(16'h0100 + 16'($random(seed) & 8'h7f), r);
            check("unmapped_rd", r, 8'h00);
        end
        for (k = 0; k < 20; k++) begin
            @(posedge mclk_in) irq_pend <= 1'($random(seed));
            cycles(1);
            check("irq_follow", proc_irq, irq_pend);
        end
        $display("Test addr20_and_irq done");

        for (t = 0; t < 4; t++) begin
            c0 = icount;
            case (t)
                0: wr(csc_pkg::SYS_PORT_ADDR, 8'h01);
                1: begin
                    @(posedge mclk_in) shut <= 1'b1;
                    @(posedge mclk_in) shut <= 1'b0;
                end
                2: begin
                    @(posedge mclk_in) pins.kbc_reset_request_n <= 1'b0;
                    cycles(8);
                    @(posedge mclk_in) pins.kbc_reset_request_n <= 1'b1;
                end
                default: begin
                    wr(csc_pkg::RST_CTRL_ADDR, 8'h00);
                    wr(csc_pkg::RST_CTRL_ADDR, 8'h04);
                end
            endcase
            cycles(10);
            wr(csc_pkg::SYS_PORT_ADDR, 8'h01);
            wait_init(c0);
            check("init_width", iwidth, csc_pkg::INIT_CYC);
            cycles(80);
            check("init_once", icount, c0 + 1);
        end
        // Bit 2 already set: no rising change, so no init
        c0 = icount;
        wr(csc_pkg::RST_CTRL_ADDR, 8'h04);
        cycles(80);
        check("init_no_toggle", icount, c0);
        $display("Test init done");

        wr(csc_pkg::SYS_PORT_ADDR, 8'h02);
        wr(csc_pkg::FPU_CTRL_ADDR, 8'h00);
        wr(csc_pkg::RST_CTRL_ADDR, 8'h00);
        wr(csc_pkg::RST_CTRL_ADDR, 8'h06);
        cycles(3);
        check("hard_rst_on", proc_rst, 1'b1);
        wait_rst(n);
        check("hard_hold", n >= RST_CYC - 3, 1'b1);
        rd(csc_pkg::SYS_PORT_ADDR, r);
        check("hard_sys_port", r, csc_pkg::SYS_PORT_RST);
        rd(csc_pkg::FPU_CTRL_ADDR, r);
        check("hard_fpu_ctrl", r, csc_pkg::FPU_CTRL_RST);
        rd(csc_pkg::RST_CTRL_ADDR, r);
        check("hard_rst_ctrl", r, csc_pkg::RST_CTRL_RST);
        $display("Test hard_reset done");

        wr(csc_pkg::FPU_CLR_ADDR, 8'h00);
        cycles(4);
        check("ign_no_err", ignoring, 1'b0);
        @(posedge mclk_in) pins.fpu_error_n <= 1'b0;
        cycles(6);
        check("fpu_irq_on", fpu_irq, 1'b1);
        wr(csc_pkg::FPU_CLR_ADDR, 8'h00);
        cycles(3);
        check("ign_set", ignoring, 1'b1);
        rd(csc_pkg::STATUS_ADDR, r);
        check("status_ign", r, (8'h01 << csc_pkg::ST_IGNORE_BIT) | (8'h01 << csc_pkg::ST_FPU_IRQ_BIT));
        cycles(20);
        check("ign_hold", ignoring, 1'b1);
        @(posedge mclk_in) pins.fpu_error_n <= 1'b1;
        cycles(6);
        check("ign_drop", ignoring, 1'b0);
        check("fpu_irq_off", fpu_irq, 1'b0);
        wr(csc_pkg::FPU_CTRL_ADDR, 8'h00);
        @(posedge mclk_in) pins.fpu_error_n <= 1'b0;
        cycles(6);
        wr(csc_pkg::FPU_CLR_ADDR, 8'h00);
        cycles(4);
        check("ign_disabled", ignoring, 1'b0);
        @(posedge mclk_in) pins.fpu_error_n <= 1'b1;
        $display("Test fpu_error done");

        // Second reset with the strap high: reset and init become active low
        @(posedge mclk_in) begin
            pins.processor_type_strap <= 1'b1;
            reset_n_in                <= 1'b0;
        end
        cycles(4);
        @(posedge mclk_in) reset_n_in <= 1'b1;
        cycles(8);
        check("new_rst_hold", proc_rst, 1'b0);
        check("new_init_idle", init, 1'b1);
        cycles(RST_CYC + 4);
        check("new_rst_free", proc_rst, 1'b1);
        rd(csc_pkg::STATUS_ADDR, r);
        check("status_strap", r, 8'h01 << csc_pkg::ST_STRAP_BIT);
        c0 = icount;
        wr(csc_pkg::SYS_PORT_ADDR, 8'h01);
        wait_init(c0);
        check("new_init_width", iwidth, csc_pkg::INIT_CYC);
        $display("Test strap_newer done");
        report_and_stop();
    end
endmodule
